//--- hdl/timer0_core.sv
`timescale 1ns/1ps
// How it works
// - Source bit clear counts instruction cycles
// - Count write blocks two instruction cycles
// - Source bit set counts pin edges, edge-selected
// - Prescaler serves counter or watchdog, assign bit
// - Counter prescale ratios 1:2 through 1:256
// - Watchdog owns prescaler, counter runs 1:1
// - Prescaler count hidden from software
// - Count write clears counter-owned prescaler
// - Watchdog clear clears watchdog-owned prescaler
// - Rollover FF to 00 sets overflow flag
// - Enable bit masks request, flag still set
// - Sleep stops counting, no wake
// - Prescaler output sampled on quarters two, four
// - Pin edges synchronised first, then prescaled
// - Ripple prescaler output is symmetrical
// - Increment three to seven oscillator periods later
// - Assignment and ratio changeable on the fly
module timer0_core
  import timer0_pkg::*;
#(
  parameter int PRESCALE_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Count pin
  input wire logic count_input_pin,
  // Watchdog side
  input wire logic wdt_raw_tick,
  output logic wdt_scaled_tick,
  // Status
  output logic overflow_irq,
  output logic [7:0] port_a_direction
);
  logic [7:0] timer_count_reg;
  logic [7:0] next_timer_count_reg;
  logic [7:0] interrupt_control_reg;
  logic [7:0] next_interrupt_control_reg;
  logic [7:0] timer_option_config;
  logic [7:0] next_timer_option_config;
  logic [7:0] next_port_a_direction;
  logic sleep_mode;
  logic next_sleep_mode;
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic [1:0] hold_cnt;
  logic [1:0] next_hold_cnt;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic next_pin_prev;
  logic samp;
  logic next_samp;
  logic samp_prev;
  logic next_samp_prev;
  logic q2_en;
  logic q4_en;
  logic ps_tap;
  logic ps_tick;
  logic ps_clear;
  logic ps_step;
  logic [7:0] idx;
  logic acc_ok;
  logic wr_take;
  logic lane0;
  logic count_wr;
  logic wdt_clear;
  logic clk_source_select;
  logic count_edge_select;
  logic prescaler_assign;
  logic [RATIO_W-1:0] prescale_ratio_field;
  logic pin_edge;
  logic sync_in;
  logic inc_req;
  logic inc;
  logic overflow_event;

  // Option fields
  assign clk_source_select = timer_option_config[OPT_CLK_SRC];
  assign count_edge_select = timer_option_config[OPT_EDGE];
  assign prescaler_assign = timer_option_config[OPT_ASSIGN];
  assign prescale_ratio_field =
    timer_option_config[OPT_RATIO_LSB +: RATIO_W];

  // Bus decode; word index from the byte address
  assign idx = address[ADDR_W-1:2];
  assign acc_ok = (read | write) & ~ack;
  assign wr_take = write & ack;
  assign lane0 = byteenable[0];
  assign count_wr = wr_take & lane0 & (idx == IDX_COUNT);
  assign wdt_clear = wr_take & lane0 & (idx == IDX_CORE_CTL) &
                     writedata[CTL_WDT_CLEAR];
  assign waitrequest = (read | write) & ~ack;

  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= count_input_pin;
      pin_sync <= pin_meta;
    end
  end

  quarter_phase_gen u_phase (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .q2_en(q2_en),
    .q4_en(q4_en)
  );

  // Chosen pin edge: rising when edge bit clear, falling when set
  assign pin_edge = count_edge_select ? (pin_prev & ~pin_sync) :
                                        (~pin_prev & pin_sync);

  // Prescaler steps from whichever party owns it
  always_comb begin
    ps_step = 1'b0;
    if (prescaler_assign) begin
      ps_step = wdt_raw_tick;
    end else if (clk_source_select) begin
      ps_step = pin_edge;
    end else begin
      ps_step = q4_en & ~sleep_mode;
    end
    // Clear source follows the current owner
    ps_clear = prescaler_assign ? wdt_clear : count_wr;
  end

  // Count not readable from the bus; count or watchdog-clear writes only zero it
  shared_prescaler #(
    .WIDTH(PRESCALE_W)
  ) u_prescaler (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clear(ps_clear),
    .step(ps_step),
    .ratio(prescale_ratio_field),
    .tap(ps_tap),
    .tick(ps_tick)
  );

  // Watchdog sees ticks only while it owns the prescaler
  assign wdt_scaled_tick = prescaler_assign & ps_tick;

  // Level handed to the quarter-phase sampler
  always_comb begin
    if (!prescaler_assign) begin
      sync_in = ps_tap;
    end else begin
      sync_in = pin_sync ^ count_edge_select;
    end
  end

  // Sample on Q2 and Q4, then detect the rising level
  always_comb begin
    next_pin_prev = pin_sync;
    next_samp = samp;
    next_samp_prev = samp_prev;
    if (q2_en | q4_en) begin
      next_samp = sync_in;
      next_samp_prev = samp;
    end
  end

  // Pin rests low and reset selects the falling edge, so the sampled
  // level starts high; starting low would count a false edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_prev <= 1'b0;
      samp <= OPTION_RST[OPT_EDGE];
      samp_prev <= OPTION_RST[OPT_EDGE];
    end else begin
      pin_prev <= next_pin_prev;
      samp <= next_samp;
      samp_prev <= next_samp_prev;
    end
  end

  // Increment request per mode; pin path lands within 3..7 periods
  always_comb begin
    if (clk_source_select) begin
      inc_req = samp & ~samp_prev & ~(q2_en | q4_en);
    end else if (prescaler_assign) begin
      inc_req = q4_en;
    end else begin
      inc_req = ps_tick;
    end
  end

  // Sleep and the post-write hold both block the count
  assign inc = inc_req & ~sleep_mode & (hold_cnt == 2'h0);
  assign overflow_event = inc & (timer_count_reg == 8'hff);

  // Post-write hold counter, measured in instruction cycles
  always_comb begin
    next_hold_cnt = hold_cnt;
    if (count_wr) begin
      next_hold_cnt = 2'(WRITE_HOLD_ICYC);
    end else if (q4_en && hold_cnt != 2'h0) begin
      next_hold_cnt = hold_cnt - 2'h1;
    end
  end

  // Register file next values
  always_comb begin
    next_timer_count_reg = timer_count_reg;
    next_interrupt_control_reg = interrupt_control_reg;
    next_timer_option_config = timer_option_config;
    next_port_a_direction = port_a_direction;
    next_sleep_mode = sleep_mode;
    next_ack = acc_ok;
    next_readdata = readdata;
    if (count_wr) begin
      next_timer_count_reg = writedata[7:0];
    end else if (inc) begin
      next_timer_count_reg = timer_count_reg + 8'h01;
    end
    if (wr_take && lane0) begin
      unique case (idx)
        IDX_INTCTL: next_interrupt_control_reg = writedata[7:0];
        // Ratio and owner may change while running
        IDX_OPTION: next_timer_option_config = writedata[7:0];
        IDX_PORTA_DIR:
          next_port_a_direction = writedata[7:0] & PORTA_DIR_MASK;
        IDX_CORE_CTL: next_sleep_mode = writedata[CTL_SLEEP];
        default: next_sleep_mode = sleep_mode;
      endcase
    end
    // Hardware set wins over a same-cycle software clear
    if (overflow_event) begin
      next_interrupt_control_reg[INT_FLAG] = 1'b1;
    end
    if (acc_ok && read) begin
      next_readdata = 32'h0000_0000;
      unique case (idx)
        IDX_COUNT: next_readdata[7:0] = timer_count_reg;
        IDX_INTCTL: next_readdata[7:0] = interrupt_control_reg;
        IDX_OPTION: next_readdata[7:0] = timer_option_config;
        IDX_PORTA_DIR: next_readdata[7:0] = port_a_direction;
        IDX_CORE_CTL: next_readdata[CTL_SLEEP] = sleep_mode;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timer_count_reg <= COUNT_RST;
      interrupt_control_reg <= INTCTL_RST;
      timer_option_config <= OPTION_RST;
      port_a_direction <= PORTA_DIR_RST;
      sleep_mode <= 1'b0;
      ack <= 1'b0;
      readdata <= 32'h0000_0000;
      hold_cnt <= 2'h0;
    end else begin
      timer_count_reg <= next_timer_count_reg;
      interrupt_control_reg <= next_interrupt_control_reg;
      timer_option_config <= next_timer_option_config;
      port_a_direction <= next_port_a_direction;
      sleep_mode <= next_sleep_mode;
      ack <= next_ack;
      readdata <= next_readdata;
      hold_cnt <= next_hold_cnt;
    end
  end

  // Flag stays sticky; the enable only masks the request
  // Software must clear it itself before re-enabling
  assign overflow_irq = interrupt_control_reg[INT_FLAG] &
                        interrupt_control_reg[INT_ENABLE];
endmodule

//--- include/timer0_pkg.sv
package timer0_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_COUNT = 8'h01;
  localparam logic [7:0] IDX_INTCTL = 8'h0b;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PORTA_DIR = 8'h85;
  localparam logic [7:0] IDX_CORE_CTL = 8'h90;
  localparam int ADDR_W = 10;

  // Reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] PORTA_DIR_RST = 8'h3f;
  localparam logic [7:0] PORTA_DIR_MASK = 8'h3f;

  // Option fields
  localparam int OPT_CLK_SRC = 5;
  localparam int OPT_EDGE = 4;
  localparam int OPT_ASSIGN = 3;
  localparam int OPT_RATIO_LSB = 0;
  localparam int RATIO_W = 3;

  // Interrupt control fields
  localparam int INT_ENABLE = 5;
  localparam int INT_FLAG = 2;

  // Core control fields
  localparam int CTL_SLEEP = 0;
  localparam int CTL_WDT_CLEAR = 1;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TOSC_NS = 10;
  localparam int WRITE_HOLD_ICYC = 2;
  localparam int INC_DELAY_MIN_TOSC = 3;
  localparam int INC_DELAY_MAX_TOSC = 7;
  localparam int INC_DELAY_MIN_CYC =
    (INC_DELAY_MIN_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INC_DELAY_MAX_CYC =
    (INC_DELAY_MAX_TOSC * TOSC_NS) / CLK_PERIOD_NS;
  localparam int QUARTERS = 4;
endpackage

//--- hdl/quarter_phase_gen.sv
`timescale 1ns/1ps
module quarter_phase_gen
  import timer0_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Phase enables
  output logic q2_en,
  output logic q4_en
);
  logic [1:0] phase;
  logic [1:0] next_phase;

  // One oscillator period per quarter
  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      phase <= 2'h0;
    end else begin
      phase <= next_phase;
    end
  end

  // Second and fourth quarters of each instruction cycle
  assign q2_en = (phase == 2'h1);
  assign q4_en = (phase == 2'h3);
endmodule

//--- hdl/shared_prescaler.sv
`timescale 1ns/1ps
module shared_prescaler
  import timer0_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic [RATIO_W-1:0] ratio,
  // Divided output
  output logic tap,
  output logic tick
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic tap_d;
  logic next_tap_d;

  // Clear has priority so a write never leaves a stale residue
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (step) begin
      next_count = count + 1'b1;
    end
    next_tap_d = count[ratio];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count <= '0;
      tap_d <= 1'b0;
    end else begin
      count <= next_count;
      tap_d <= next_tap_d;
    end
  end

  // Tap bit is a symmetric square wave
  assign tap = count[ratio];
  assign tick = count[ratio] & ~tap_d;
endmodule

//--- bench/timer0_core_properties.sv
`timescale 1ns/1ps
module timer0_core_properties
  import timer0_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Bus and status
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic wdt_scaled_tick,
  input wire logic overflow_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Shadow of option and sleep, since the ports hide both
  logic [7:0] opt;
  logic slp;
  wire wr_ok = write && !waitrequest && byteenable[0];
  wire int_wr = wr_ok && address == 10'h02c;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      opt <= 8'hff;
      slp <= 1'b0;
    end else if (wr_ok && address == 10'h204) begin
      opt <= writedata[7:0];
    end else if (wr_ok && address == 10'h240) begin
      slp <= writedata[0];
    end
  end
  chk_wait_one: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("wait longer than one cycle");
  chk_wait_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("wait without request");
  chk_read_upper: assert property (
    read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  chk_irq_set: assert property (
    int_wr && writedata[5] && writedata[2] |=> overflow_irq)
    else $error("irq missing");
  chk_irq_masked: assert property (
    int_wr && !writedata[5] |=> !overflow_irq)
    else $error("irq not masked");
  chk_irq_sticky: assert property (
    overflow_irq && !int_wr |=> overflow_irq)
    else $error("irq dropped by itself");
  chk_wdt_gate: assert property (
    !opt[3] |-> !wdt_scaled_tick)
    else $error("watchdog tick while prescaler on counter");
  chk_sleep_quiet: assert property (
    slp && !int_wr |=> !$rose(overflow_irq))
    else $error("irq rose in sleep");
endmodule
bind timer0_core timer0_core_properties timer0_core_properties_inst (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .address(address),
  .read(read),
  .write(write),
  .writedata(writedata),
  .byteenable(byteenable),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .wdt_scaled_tick(wdt_scaled_tick),
  .overflow_irq(overflow_irq)
);

//--- bench/ext_count_source.sv
`timescale 1ns/1ps
module ext_count_source (
  // Clock
  input wire logic core_clk,
  // Burst request
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic [7:0] half,
  // Pin side
  output logic pin,
  output logic busy
);
  logic [8:0] halves = 9'h000;
  logic [7:0] ph = 8'h00;
  // Pin rests low between bursts, never free-running
  initial pin = 1'b0;
  assign busy = halves != 9'h000;
  always @(posedge core_clk) begin
    if (start) begin
      halves <= {pulses, 1'b0};
      ph <= 8'h00;
    end else if (busy) begin
      ph <= (ph == half - 8'h01) ? 8'h00 : ph + 8'h01;
      if (ph == half - 8'h01) begin
        pin <= ~pin;
        halves <= halves - 9'h001;
      end
    end
  end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import timer0_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hf;
  logic wdt_raw_tick = 1'b0;
  logic start = 1'b0;
  logic [7:0] pulses = 8'h00;
  logic [7:0] half = 8'h04;
  logic [31:0] readdata;
  logic waitrequest, pin, wdt_scaled_tick, overflow_irq, busy;
  logic [7:0] port_a_direction, q, q0;
  logic [3:0] tk = 4'h0;
  int n_mismatch = 0;
  int checked = 0;
  int nt = 0;
  typedef struct {logic [9:0] a; logic w; logic [7:0] d, e;} row_t;
  row_t rows [7] = '{'{10'h204, 1'b0, 8'h00, 8'hff},
    '{10'h214, 1'b0, 8'h00, 8'h3f}, '{10'h02c, 1'b0, 8'h00, 8'h00},
    '{10'h004, 1'b0, 8'h00, 8'h00}, '{10'h214, 1'b1, 8'hff, 8'h3f},
    '{10'h3fc, 1'b1, 8'h55, 8'h00}, '{10'h240, 1'b1, 8'h02, 8'h00}};
  timer0_core timer0_core_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .count_input_pin(pin),
    .wdt_raw_tick(wdt_raw_tick), .wdt_scaled_tick(wdt_scaled_tick),
    .overflow_irq(overflow_irq), .port_a_direction(port_a_direction));
  ext_count_source ext_count_source_inst (.core_clk(core_clk),
    .start(start), .pulses(pulses), .half(half), .pin(pin), .busy(busy));
  initial forever #5 core_clk = ~core_clk;
  // Raw watchdog base every 16 clocks; count scaled ticks
  always @(posedge core_clk) begin
    tk <= tk + 4'h1;
    wdt_raw_tick <= tk == 4'hf;
    if (wdt_scaled_tick === 1'b1) nt <= nt + 1;
  end
  task automatic chk(input string nm, input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One bus transfer; waits for waitrequest low, bounded
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= w;
    read <= !w;
    @(posedge core_clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 20) n_mismatch++;
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic burst(input logic [7:0] n, h);
    pulses <= n;
    half <= h;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Run needs about 9k clocks; cut a hang at 40k
  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      if (rows[i].w) xfer(1'b1, rows[i].a, rows[i].d);
      xfer(1'b0, rows[i].a, 8'h00);
      chk($sformatf("reg %h", rows[i].a), q, rows[i].e);
    end
    // Every ratio, then watchdog-owned 1:1; four steps per window
    for (int k = 0; k < 9; k++) begin
      // Owner switch: clear count, then watchdog, then new option
      xfer(1'b1, 10'h004, 8'h00);
      xfer(1'b1, 10'h240, 8'h02);
      xfer(1'b1, 10'h204, k < 8 ? 8'(k) : 8'h08);
      xfer(1'b1, 10'h004, 8'h10);
      xfer(1'b0, 10'h004, 8'h00);
      chk("count held", q, 8'h10);
      repeat (9) @(posedge core_clk);
      xfer(1'b0, 10'h004, 8'h00);
      q0 = q;
      repeat ((k < 8 ? 16 << (k + 1) : 16) - 3) @(posedge core_clk);
      xfer(1'b0, 10'h004, 8'h00);
      chk("count rate", q - q0, 8'h04);
    end
    q0 = 8'(nt);
    repeat (200) @(posedge core_clk);
    chk("wdt ticks", 8'(nt != int'(q0)), 8'h01);
    xfer(1'b1, 10'h02c, 8'h00);
    xfer(1'b1, 10'h004, 8'hff);
    repeat (20) @(posedge core_clk);
    xfer(1'b0, 10'h02c, 8'h00);
    chk("flag", q, 8'h04);
    chk("irq masked", {7'h00, overflow_irq}, 8'h00);
    xfer(1'b1, 10'h02c, 8'h24);
    chk("irq on", {7'h00, overflow_irq}, 8'h01);
    xfer(1'b1, 10'h02c, 8'h20);
    chk("irq cleared", {7'h00, overflow_irq}, 8'h00);
    xfer(1'b1, 10'h240, 8'h01);
    xfer(1'b0, 10'h004, 8'h00);
    q0 = q;
    repeat (40) @(posedge core_clk);
    xfer(1'b0, 10'h004, 8'h00);
    chk("sleep", q, q0);
    xfer(1'b1, 10'h240, 8'h00);
    // Slow pulse: only the rising setting counts before the fall
    for (int e = 0; e < 2; e++) begin
      xfer(1'b1, 10'h204, e ? 8'h38 : 8'h28);
      xfer(1'b1, 10'h004, 8'h00);
      repeat (10) @(posedge core_clk);
      burst(8'h01, 8'h28);
      repeat (60) @(posedge core_clk);
      xfer(1'b0, 10'h004, 8'h00);
      chk("edge", q, e ? 8'h00 : 8'h01);
      while (busy === 1'b1) @(posedge core_clk);
      repeat (20) @(posedge core_clk);
      xfer(1'b0, 10'h004, 8'h00);
      chk("edge end", q, 8'h01);
    end
    xfer(1'b1, 10'h240, 8'h02);
    xfer(1'b1, 10'h204, 8'h20);
    xfer(1'b1, 10'h004, 8'h00);
    repeat (10) @(posedge core_clk);
    burst(8'h06, 8'h04);
    while (busy === 1'b1) @(posedge core_clk);
    repeat (20) @(posedge core_clk);
    xfer(1'b0, 10'h004, 8'h00);
    chk("pin prescaled", q, 8'h03);
    // Non-reset direction value so the reset check can fail
    xfer(1'b1, 10'h214, 8'h15);
    chk("dir write", port_a_direction, 8'h15);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    xfer(1'b0, 10'h204, 8'h00);
    chk("option reset", q, 8'hff);
    xfer(1'b0, 10'h004, 8'h00);
    chk("count reset", q, 8'h00);
    chk("dir reset", port_a_direction, 8'h3f);
    tally_and_finish;
  end
endmodule
